// ==== src/dtcm_timer.sv ====
/*
 * Dual timer/counter with AXI4-Lite register access and one interrupt.
 * Assumes count and gate pins are asynchronous; bus is on CLOCK.
 */
// What this block does
// - Timer function counts prescaled clock; counter function counts pin edges.
// - Two-bit mode: 13-bit, 16-bit, 8-bit reload; timer 1 mode 3 stops.
// - Count only when run bit set and gate off or gate pin high.
// - Mode 0 is 13 bits: high byte over low five bits of low byte.
// - Rollover from all ones to zero sets the timer overflow flag.
// - Setting run bit leaves count registers untouched.
// - Mode 1 cascades both bytes into a 16-bit counter.
// - Mode 2 counts low byte, reloads it from high byte on overflow.
// - Timer 1 in mode 3 holds its count as if run bit cleared.
// - Timer 0 mode 3 low byte is 8-bit counter with timer 0 controls.
// - Timer 0 mode 3 high byte times only, uses timer 1 run and flag.
// - Timer 1 keeps counting flagless while timer 0 is in mode 3.
// - Mode register: timer 1 in bits 7..4, timer 0 in bits 3..0.
// - Mode register resets to zero and is software read/write.
// - Timer function advances once per twelve oscillator periods.
// - Pin sampled per twelve periods; one then zero counts next period.
// - Flags set by hardware, cleared on service; run bits read/write.
`timescale 1ns/10ps
`default_nettype none
module dtcm_timer
    import dtcm_pkg::*;
(
    input  wire logic          CLOCK,
    input  wire logic          RESETN,
    input  wire dtcm_axi_req_t AXI_REQ,
    output dtcm_axi_rsp_t      AXI_RSP,
    input  wire logic          COUNT_PIN_ZERO,
    input  wire logic          COUNT_PIN_ONE,
    input  wire logic          GATE_PIN_ZERO,
    input  wire logic          GATE_PIN_ONE,
    input  wire logic [1:0]    SERVICE_ACK,
    output logic               IRQ
);

    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    logic [3:0] tick_count;
    logic       tick;
    logic [1:0] cnt_sample;
    logic [1:0] cnt_fall;
    logic [7:0] timer_mode_select;
    logic       run_bit_zero;
    logic       run_bit_one;
    logic       overflow_flag_zero;
    logic       overflow_flag_one;
    logic [1:0] int_mask;
    logic [7:0] count_low_zero;
    logic [7:0] count_high_zero;
    logic [7:0] count_low_one;
    logic [7:0] count_high_one;
    logic       aw_held;
    logic [9:0] aw_index;
    logic       w_held;
    logic [7:0] w_byte;
    logic       w_lane;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic       wr_fire;
    logic       ar_fire;
    logic       wr_mode;
    logic       wr_ctl;
    logic       wr_tl0;
    logic       wr_th0;
    logic       wr_tl1;
    logic       wr_th1;
    logic       wr_stat;
    logic       wr_mask;
    logic       wr_known;
    logic [1:0] mode0;
    logic [1:0] mode1;
    logic       split0;
    logic       en0;
    logic       en1;
    logic       ev0;
    logic       ev1;
    logic       evh;
    dtcm_cnt_t  step0;
    dtcm_cnt_t  step1;
    logic       set0;
    logic       set1;
    logic [1:0] clr;

    // One step of a paired counter in modes 0 to 2
    function automatic dtcm_cnt_t count_step(input logic [1:0] m,
                                             input logic [7:0] h,
                                             input logic [7:0] l);
        dtcm_cnt_t r;
        r = '{high: h, low: l, ovf: 1'b0};
        case (m)
            MODE_13BIT: begin
                r.low[4:0] = 5'(l[4:0] + 5'h1);
                if (l[4:0] == 5'h1f) begin
                    r.high = 8'(h + 8'h01);
                    r.ovf  = (h == 8'hff);
                end
            end
            MODE_16BIT: begin
                {r.high, r.low} = 16'({h, l} + 16'h0001);
                r.ovf = ({h, l} == 16'hffff);
            end
            MODE_RELOAD: begin
                r.low = (l == 8'hff) ? h : 8'(l + 8'h01);
                r.ovf = (l == 8'hff);
            end
            default: r = '{high: h, low: l, ovf: 1'b0};
        endcase
        return r;
    endfunction

    // Two-stage synchroniser for the four pins
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            pin_meta <= 4'h0;
            pin_sync <= 4'h0;
        end else begin
            pin_meta <= {GATE_PIN_ONE, GATE_PIN_ZERO,
                         COUNT_PIN_ONE, COUNT_PIN_ZERO};
            pin_sync <= pin_meta;
        end
    end

    // Divide by twelve, untouched by bus activity
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            tick_count <= 4'h0;
        end else if (tick) begin
            tick_count <= 4'h0;
        end else begin
            tick_count <= 4'(tick_count + 4'h1);
        end
    end
    assign tick = (tick_count == 4'(TICK_CYCLES - 1));

    // Count pins sampled on the tick; fall counts on the next tick
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            cnt_sample <= 2'h0;
            cnt_fall   <= 2'h0;
        end else if (tick) begin
            cnt_sample <= pin_sync[1:0];
            cnt_fall   <= cnt_sample & ~pin_sync[1:0];
        end
    end

    assign mode0  = timer_mode_select[MODE_SEL_ZERO +: 2];
    assign mode1  = timer_mode_select[MODE_SEL_ONE +: 2];
    assign split0 = (mode0 == MODE_SPLIT);

    assign en0 = run_bit_zero &
                 (~timer_mode_select[MODE_GATE_ZERO] | pin_sync[2]);
    assign en1 = run_bit_one & (mode1 != MODE_SPLIT) &
                 (~timer_mode_select[MODE_GATE_ONE] | pin_sync[3]);
    assign ev0 = en0 & (timer_mode_select[MODE_FUNC_ZERO] ?
                        cnt_fall[0] & tick : tick);
    assign ev1 = en1 & (timer_mode_select[MODE_FUNC_ONE] ?
                        cnt_fall[1] & tick : tick);
    assign evh = split0 & run_bit_one & tick;

    assign step0 = count_step(mode0, count_high_zero, count_low_zero);
    assign step1 = count_step(mode1, count_high_one, count_low_one);

    assign set0 = split0 ? (ev0 & (count_low_zero == 8'hff))
                         : (ev0 & step0.ovf);
    assign set1 = split0 ? (evh & (count_high_zero == 8'hff))
                         : (ev1 & step1.ovf);
    assign clr  = SERVICE_ACK | ({2{wr_stat}} & w_byte[1:0]);

    // Timer 0 count registers; a software write wins over counting
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            count_low_zero  <= COUNT_RESET;
            count_high_zero <= COUNT_RESET;
        end else begin
            if (wr_tl0) begin
                count_low_zero <= w_byte;
            end else if (split0 && ev0) begin
                count_low_zero <= 8'(count_low_zero + 8'h01);
            end else if (!split0 && ev0) begin
                count_low_zero <= step0.low;
            end
            if (wr_th0) begin
                count_high_zero <= w_byte;
            end else if (split0 && evh) begin
                count_high_zero <= 8'(count_high_zero + 8'h01);
            end else if (!split0 && ev0) begin
                count_high_zero <= step0.high;
            end
        end
    end

    // Timer 1 count registers
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            count_low_one  <= COUNT_RESET;
            count_high_one <= COUNT_RESET;
        end else begin
            if (wr_tl1) begin
                count_low_one <= w_byte;
            end else if (ev1) begin
                count_low_one <= step1.low;
            end
            if (wr_th1) begin
                count_high_one <= w_byte;
            end else if (ev1) begin
                count_high_one <= step1.high;
            end
        end
    end

    // Overflow flags: a set in the clearing cycle wins
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            overflow_flag_zero <= 1'b0;
            overflow_flag_one  <= 1'b0;
        end else begin
            overflow_flag_zero <= set0 | (overflow_flag_zero & ~clr[0]);
            overflow_flag_one  <= set1 | (overflow_flag_one & ~clr[1]);
        end
    end

    // Mode, run and mask registers
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            timer_mode_select <= MODE_RESET;
            run_bit_zero      <= 1'b0;
            run_bit_one       <= 1'b0;
            int_mask          <= 2'h0;
        end else begin
            if (wr_mode) begin
                timer_mode_select <= w_byte;
            end
            if (wr_ctl) begin
                run_bit_zero <= w_byte[CTL_RUN_ZERO];
                run_bit_one  <= w_byte[CTL_RUN_ONE];
            end
            if (wr_mask) begin
                int_mask <= w_byte[1:0];
            end
        end
    end

    assign IRQ = |({overflow_flag_one, overflow_flag_zero} & int_mask);

    // AXI4-Lite write side: address and data taken in either order
    assign wr_fire  = aw_held & w_held & ~bvalid;
    assign wr_mode  = wr_fire & w_lane & (aw_index == IDX_MODE);
    assign wr_ctl   = wr_fire & w_lane & (aw_index == IDX_RUN_FLAG);
    assign wr_tl0   = wr_fire & w_lane & (aw_index == IDX_LOW_ZERO);
    assign wr_th0   = wr_fire & w_lane & (aw_index == IDX_HIGH_ZERO);
    assign wr_tl1   = wr_fire & w_lane & (aw_index == IDX_LOW_ONE);
    assign wr_th1   = wr_fire & w_lane & (aw_index == IDX_HIGH_ONE);
    assign wr_stat  = wr_fire & w_lane & (aw_index == IDX_INT_STAT);
    assign wr_mask  = wr_fire & w_lane & (aw_index == IDX_INT_MASK);
    assign wr_known = (aw_index inside {IDX_MODE, IDX_RUN_FLAG, IDX_LOW_ZERO,
                       IDX_HIGH_ZERO, IDX_LOW_ONE, IDX_HIGH_ONE,
                       IDX_INT_STAT, IDX_INT_MASK});

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            aw_held  <= 1'b0;
            aw_index <= 10'h000;
            w_held   <= 1'b0;
            w_byte   <= 8'h00;
            w_lane   <= 1'b0;
            bvalid   <= 1'b0;
            bresp    <= RESP_OKAY;
        end else begin
            if (AXI_REQ.awvalid && !aw_held) begin
                aw_held  <= 1'b1;
                aw_index <= AXI_REQ.awaddr[11:2];
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end
            if (AXI_REQ.wvalid && !w_held) begin
                w_held <= 1'b1;
                w_byte <= AXI_REQ.wdata[7:0];
                w_lane <= AXI_REQ.wstrb[0];
            end else if (wr_fire) begin
                w_held <= 1'b0;
            end
            if (wr_fire) begin
                bvalid <= 1'b1;
                bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end else if (AXI_REQ.bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // AXI4-Lite read side: data one cycle after the address
    assign ar_fire = AXI_REQ.arvalid & ~rvalid;

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= RESP_OKAY;
        end else if (ar_fire) begin
            rvalid <= 1'b1;
            rresp  <= RESP_OKAY;
            case (AXI_REQ.araddr[11:2])
                IDX_MODE:      rdata <= {24'h00_0000, timer_mode_select};
                IDX_RUN_FLAG:  rdata <= {24'h00_0000, overflow_flag_one,
                                         run_bit_one, overflow_flag_zero,
                                         run_bit_zero, 4'h0};
                IDX_LOW_ZERO:  rdata <= {24'h00_0000, count_low_zero};
                IDX_HIGH_ZERO: rdata <= {24'h00_0000, count_high_zero};
                IDX_LOW_ONE:   rdata <= {24'h00_0000, count_low_one};
                IDX_HIGH_ONE:  rdata <= {24'h00_0000, count_high_one};
                IDX_INT_STAT:  rdata <= {30'h0000_0000, overflow_flag_one,
                                         overflow_flag_zero};
                IDX_INT_MASK:  rdata <= {30'h0000_0000, int_mask};
                default: begin
                    rdata <= 32'h0000_0000;
                    rresp <= RESP_SLVERR;
                end
            endcase
        end else if (AXI_REQ.rready) begin
            rvalid <= 1'b0;
        end
    end

    always_comb begin
        AXI_RSP.awready = ~aw_held;
        AXI_RSP.wready  = ~w_held;
        AXI_RSP.bvalid  = bvalid;
        AXI_RSP.bresp   = bresp;
        AXI_RSP.arready = ~rvalid;
        AXI_RSP.rvalid  = rvalid;
        AXI_RSP.rdata   = rdata;
        AXI_RSP.rresp   = rresp;
    end

    // Checks
    property p_tick_period;
        @(posedge CLOCK) disable iff (!RESETN)
        tick |=> !tick [*8] ##1 !tick [*3] ##1 tick;
    endproperty
    a_tick_period: assert property (p_tick_period)
        else $error("tick spacing is not twelve cycles");

    property p_gated_hold;
        @(posedge CLOCK) disable iff (!RESETN)
        (!run_bit_zero && !wr_tl0) |=> $stable(count_low_zero);
    endproperty
    a_gated_hold: assert property (p_gated_hold)
        else $error("low byte of timer 0 moved while stopped");

    property p_mode0_carry;
        @(posedge CLOCK) disable iff (!RESETN)
        (!split0 && mode0 == MODE_13BIT && ev0 && !wr_th0 && !wr_tl0 &&
         count_low_zero[4:0] == 5'h1f)
        |=> count_high_zero == 8'($past(count_high_zero) + 8'h01) &&
            count_low_zero[4:0] == 5'h00;
    endproperty
    a_mode0_carry: assert property (p_mode0_carry)
        else $error("13-bit carry into high byte wrong");

    property p_mode1_wrap;
        @(posedge CLOCK) disable iff (!RESETN)
        (mode1 == MODE_16BIT && ev1 && !wr_tl1 && !wr_th1 &&
         {count_high_one, count_low_one} == 16'hffff && !split0)
        |=> {count_high_one, count_low_one} == 16'h0000 && overflow_flag_one;
    endproperty
    a_mode1_wrap: assert property (p_mode1_wrap)
        else $error("16-bit rollover did not wrap and flag");

    property p_reload;
        @(posedge CLOCK) disable iff (!RESETN)
        (mode0 == MODE_RELOAD && ev0 && count_low_zero == 8'hff &&
         !wr_tl0 && !wr_th0)
        |=> count_low_zero == $past(count_high_zero) &&
            $stable(count_high_zero) && overflow_flag_zero;
    endproperty
    a_reload: assert property (p_reload)
        else $error("auto-reload did not load low from high");

    property p_stop_one;
        @(posedge CLOCK) disable iff (!RESETN)
        (mode1 == MODE_SPLIT && !wr_tl1 && !wr_th1)
        |=> $stable(count_low_one) && $stable(count_high_one);
    endproperty
    a_stop_one: assert property (p_stop_one)
        else $error("timer 1 counted in mode 3");

    property p_split_high;
        @(posedge CLOCK) disable iff (!RESETN)
        (split0 && run_bit_one && tick && count_high_zero == 8'hff &&
         !wr_th0) |=> count_high_zero == 8'h00 && overflow_flag_one;
    endproperty
    a_split_high: assert property (p_split_high)
        else $error("split high byte did not flag timer 1");

    property p_split_quiet;
        @(posedge CLOCK) disable iff (!RESETN)
        (split0 && !evh && !overflow_flag_one) |=> !overflow_flag_one;
    endproperty
    a_split_quiet: assert property (p_split_quiet)
        else $error("timer 1 raised its flag while timer 0 split");

    property p_edge_count;
        @(posedge CLOCK) disable iff (!RESETN)
        (tick && cnt_sample[0] && !pin_sync[0])
        |=> (cnt_fall[0] && !tick) [*8] ##1 (cnt_fall[0] && !tick) [*3]
            ##1 (tick && cnt_fall[0]);
    endproperty
    a_edge_count: assert property (p_edge_count)
        else $error("falling sample not carried to next period");

    property p_mode_write;
        @(posedge CLOCK) disable iff (!RESETN)
        wr_mode |=> timer_mode_select == $past(w_byte);
    endproperty
    a_mode_write: assert property (p_mode_write)
        else $error("mode register did not take written byte");

    property p_flag_set_wins;
        @(posedge CLOCK) disable iff (!RESETN)
        set0 |=> overflow_flag_zero;
    endproperty
    a_flag_set_wins: assert property (p_flag_set_wins)
        else $error("overflow flag zero lost its set");

endmodule
`default_nettype wire

// ==== pkg/dtcm_pkg.sv ====
/*
 * Shared constants and types for the dual timer/counter block.
 * Assumes a single 40 MHz clock that also stands in for the oscillator.
 */
package dtcm_pkg;

    // Clock and count-rate figures
    localparam int CLOCK_HZ         = 40_000_000;
    localparam int OSC_HZ           = 40_000_000;
    localparam int TICK_OSC_PERIODS = 12;
    localparam int TICK_CYCLES      = TICK_OSC_PERIODS * CLOCK_HZ / OSC_HZ;

    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_RUN_FLAG  = 10'h088;
    localparam logic [9:0] IDX_MODE      = 10'h089;
    localparam logic [9:0] IDX_LOW_ZERO  = 10'h08a;
    localparam logic [9:0] IDX_LOW_ONE   = 10'h08b;
    localparam logic [9:0] IDX_HIGH_ZERO = 10'h08c;
    localparam logic [9:0] IDX_HIGH_ONE  = 10'h08d;
    localparam logic [9:0] IDX_INT_STAT  = 10'h090;
    localparam logic [9:0] IDX_INT_MASK  = 10'h091;

    // Reset values
    localparam logic [7:0] MODE_RESET  = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;

    // Mode register fields
    localparam int MODE_GATE_ONE = 7;
    localparam int MODE_FUNC_ONE = 6;
    localparam int MODE_SEL_ONE  = 4;
    localparam int MODE_GATE_ZERO = 3;
    localparam int MODE_FUNC_ZERO = 2;
    localparam int MODE_SEL_ZERO = 0;

    // Run/flag control register fields
    localparam int CTL_FLAG_ONE  = 7;
    localparam int CTL_RUN_ONE   = 6;
    localparam int CTL_FLAG_ZERO = 5;
    localparam int CTL_RUN_ZERO  = 4;

    // Mode encodings
    localparam logic [1:0] MODE_13BIT  = 2'h0;
    localparam logic [1:0] MODE_16BIT  = 2'h1;
    localparam logic [1:0] MODE_RELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT  = 2'h3;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic        awvalid;
        logic [11:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [11:0] araddr;
        logic        rready;
    } dtcm_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } dtcm_axi_rsp_t;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
        logic       ovf;
    } dtcm_cnt_t;

endpackage

// ==== verification/dtcm_pins_model.sv ====
/*
 * Far-side model: drives the count and gate pins of the timer block.
 * Assumes start is a one-cycle pulse given while the model is idle.
 */
`timescale 1ns/10ps
`default_nettype none
module dtcm_pins_model (
    input  wire logic       clk,
    input  wire logic       start,
    input  wire logic [3:0] npulse,
    input  wire logic [1:0] gate,
    output logic            cnt_zero,
    output logic            cnt_one,
    output logic            gate_zero,
    output logic            gate_one
);
    logic [3:0] left = 4'h0;
    logic [5:0] ph   = 6'h00;
    // Each level lasts 24 cycles, two sample periods
    always_ff @(posedge clk) begin
        if (start) begin
            left <= npulse;
            ph   <= 6'h00;
        end else if (left != 4'h0) begin
            ph <= (ph == 6'h2f) ? 6'h00 : ph + 6'h01;
            if (ph == 6'h2f) begin
                left <= left - 4'h1;
            end
        end
    end
    // Idle high, so no falling edge outside a burst
    assign cnt_zero  = !((left != 4'h0) && (ph < 6'h18));
    assign cnt_one   = cnt_zero;
    assign gate_zero = gate[0];
    assign gate_one  = gate[1];
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
/*
 * Self-checking bench for the dual timer/counter block.
 * Assumes the register map and one-cycle bus answers of the hand-over.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import dtcm_pkg::*;
    logic          CLOCK = 0;
    logic          RESETN = 0;
    logic          start = 0;
    logic [3:0]    npulse = 4'h0;
    logic [1:0]    gate = 2'h0;
    logic [1:0]    SERVICE_ACK = 2'h0;
    dtcm_axi_req_t req = '0;
    dtcm_axi_rsp_t rsp;
    logic          IRQ, c0, c1, g0, g1;
    logic [7:0]    rd, v, n;
    logic [1:0]    rr;
    int            num_errors = 0;
    int            compares = 0;
    int            cycles = 0;
    int            seed = 8005;
    always #12.5 CLOCK = ~CLOCK;
    dtcm_timer u_dtcm_timer (.CLOCK(CLOCK), .RESETN(RESETN), .AXI_REQ(req),
        .AXI_RSP(rsp), .COUNT_PIN_ZERO(c0), .COUNT_PIN_ONE(c1),
        .GATE_PIN_ZERO(g0), .GATE_PIN_ONE(g1), .SERVICE_ACK(SERVICE_ACK),
        .IRQ(IRQ));
    dtcm_pins_model u_dtcm_pins_model (.clk(CLOCK), .start(start),
        .npulse(npulse), .gate(gate), .cnt_zero(c0), .cnt_one(c1),
        .gate_zero(g0), .gate_one(g1));
    function automatic logic [7:0] mb(input logic [3:0] t1, input logic [3:0] t0);
        return {t1, t0};
    endfunction
    task automatic wrap_up;
        $display("Counts: %0d compares, %0d mismatches", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic wr(input logic [9:0] i, input logic [7:0] d);
        logic a, w;
        a = 1;
        w = 1;
        @(posedge CLOCK);
        req.awvalid <= 1;
        req.awaddr  <= {i, 2'h0};
        req.wvalid  <= 1;
        req.wdata   <= {24'h00_0000, d};
        req.wstrb   <= 4'hf;
        req.bready  <= 1;
        while (a || w) begin
            @(posedge CLOCK);
            if (a && rsp.awready) begin
                a = 0;
                req.awvalid <= 0;
            end
            if (w && rsp.wready) begin
                w = 0;
                req.wvalid <= 0;
            end
        end
        do @(posedge CLOCK); while (!rsp.bvalid);
        rr = rsp.bresp;
        req.bready <= 0;
    endtask
    task automatic rdr(input logic [9:0] i);
        @(posedge CLOCK);
        req.arvalid <= 1;
        req.araddr  <= {i, 2'h0};
        req.rready  <= 1;
        do @(posedge CLOCK); while (!rsp.arready);
        req.arvalid <= 0;
        do @(posedge CLOCK); while (!rsp.rvalid);
        rd = rsp.rdata[7:0];
        rr = rsp.rresp;
        req.rready <= 0;
    endtask
    task automatic ckr(input logic [9:0] i, input logic [7:0] e, input string m);
        rdr(i);
        chk(rd, e, m);
    endtask
    task automatic wirq(input logic e, input int lim);
        for (int k = 0; k < lim && IRQ !== e; k++) @(posedge CLOCK);
        chk({7'h00, IRQ}, {7'h00, e}, "irq level");
    endtask
    always @(posedge CLOCK) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            wrap_up();
        end
    end
    initial begin
        repeat (6) @(posedge CLOCK);
        RESETN <= 1;
        ckr(IDX_MODE, MODE_RESET, "mode reset");
        rdr(10'h0ff);
        chk({6'h00, rr}, {6'h00, RESP_SLVERR}, "unmapped resp");
        wr(10'h0ff, 8'h00);
        chk({6'h00, rr}, {6'h00, RESP_SLVERR}, "unmapped bresp");
        for (int k = 0; k < 4; k++) begin
            v = $random(seed);
            wr(IDX_MODE, v);
            ckr(IDX_MODE, v, "mode readback");
        end
        $display("Test registers done");
        wr(IDX_INT_MASK, 8'h03);
        wr(IDX_MODE, mb({2'h0, MODE_16BIT}, {2'h0, MODE_16BIT}));
        wr(IDX_LOW_ZERO, 8'h00);
        wr(IDX_HIGH_ZERO, 8'hff);
        repeat (30) @(posedge CLOCK);
        ckr(IDX_LOW_ZERO, 8'h00, "stopped");
        wr(IDX_RUN_FLAG, 8'h10);
        ckr(IDX_HIGH_ZERO, 8'hff, "run keeps count");
        wr(IDX_LOW_ZERO, 8'hff);
        wirq(1, 40);
        ckr(IDX_HIGH_ZERO, 8'h00, "16-bit wrap");
        ckr(IDX_INT_STAT, 8'h01, "flag zero");
        wr(IDX_INT_MASK, 8'h00);
        wirq(0, 4);
        wr(IDX_INT_MASK, 8'h03);
        wirq(1, 4);
        SERVICE_ACK <= 2'h1;
        @(posedge CLOCK);
        SERVICE_ACK <= 2'h0;
        wirq(0, 4);
        ckr(IDX_RUN_FLAG, 8'h10, "run kept");
        $display("Test mode 1 done");
        v = $random(seed) & 8'h7f;
        wr(IDX_RUN_FLAG, 8'h00);
        wr(IDX_MODE, mb({2'h0, MODE_RELOAD}, {2'h0, MODE_RELOAD}));
        wr(IDX_HIGH_ZERO, v);
        wr(IDX_LOW_ZERO, 8'hff);
        wr(IDX_RUN_FLAG, 8'h10);
        wirq(1, 40);
        ckr(IDX_LOW_ZERO, v, "reload low");
        ckr(IDX_HIGH_ZERO, v, "reload high");
        wr(IDX_RUN_FLAG, 8'h00);
        wr(IDX_INT_STAT, 8'h01);
        wirq(0, 4);
        wr(IDX_MODE, mb({2'h0, MODE_13BIT}, {2'h0, MODE_13BIT}));
        wr(IDX_HIGH_ZERO, 8'hff);
        wr(IDX_LOW_ZERO, 8'hff);
        wr(IDX_RUN_FLAG, 8'h10);
        wirq(1, 40);
        ckr(IDX_HIGH_ZERO, 8'h00, "13-bit high");
        ckr(IDX_LOW_ZERO, 8'he0, "13-bit low");
        wr(IDX_RUN_FLAG, 8'h00);
        wr(IDX_INT_STAT, 8'h01);
        $display("Test modes 2 and 0 done");
        wr(IDX_MODE, mb({2'h0, MODE_16BIT}, {2'h2, MODE_16BIT}));
        wr(IDX_LOW_ZERO, 8'h00);
        wr(IDX_RUN_FLAG, 8'h10);
        repeat (40) @(posedge CLOCK);
        ckr(IDX_LOW_ZERO, 8'h00, "gate closed");
        gate <= 2'h1;
        repeat (40) @(posedge CLOCK);
        rdr(IDX_LOW_ZERO);
        chk({7'h00, rd != 8'h00}, 8'h01, "gate open");
        gate <= 2'h0;
        $display("Test gate done");
        wr(IDX_RUN_FLAG, 8'h00);
        wr(IDX_MODE, mb({2'h1, MODE_16BIT}, {2'h1, MODE_16BIT}));
        wr(IDX_LOW_ZERO, 8'h00);
        wr(IDX_LOW_ONE, 8'h00);
        wr(IDX_RUN_FLAG, 8'h50);
        n = ($random(seed) & 8'h07) + 8'h01;
        npulse <= n[3:0];
        start <= 1;
        @(posedge CLOCK);
        start <= 0;
        repeat (n * 48 + 60) @(posedge CLOCK);
        ckr(IDX_LOW_ZERO, n, "edges zero");
        ckr(IDX_LOW_ONE, n, "edges one");
        wr(IDX_MODE, mb({2'h1, MODE_SPLIT}, {2'h1, MODE_16BIT}));
        npulse <= 4'h3;
        start <= 1;
        @(posedge CLOCK);
        start <= 0;
        repeat (210) @(posedge CLOCK);
        ckr(IDX_LOW_ONE, n, "mode 3 holds");
        ckr(IDX_LOW_ZERO, n + 8'h03, "still counts");
        $display("Test counter done");
        wr(IDX_RUN_FLAG, 8'h00);
        wr(IDX_MODE, mb({2'h0, MODE_16BIT}, {2'h2, MODE_SPLIT}));
        wr(IDX_HIGH_ZERO, 8'hff);
        wr(IDX_RUN_FLAG, 8'h40);
        wirq(1, 40);
        ckr(IDX_INT_STAT, 8'h02, "split flag one");
        ckr(IDX_HIGH_ZERO, 8'h00, "split high");
        wr(IDX_INT_STAT, 8'h02);
        wr(IDX_HIGH_ONE, 8'hff);
        wr(IDX_LOW_ONE, 8'hff);
        repeat (40) @(posedge CLOCK);
        ckr(IDX_HIGH_ONE, 8'h00, "t1 wraps in split");
        ckr(IDX_INT_STAT, 8'h00, "t1 flagless");
        wr(IDX_MODE, mb({2'h0, MODE_16BIT}, {2'h2, MODE_16BIT}));
        wr(IDX_HIGH_ONE, 8'hff);
        wr(IDX_LOW_ONE, 8'hff);
        wirq(1, 40);
        ckr(IDX_INT_STAT, 8'h02, "t1 16-bit flag");
        $display("Test split done");
        wrap_up();
    end
endmodule
`default_nettype wire
